// ===== rtl/spc_pkg.sv
package spc_pkg;

    // Register byte addresses
    localparam logic [7:0] ADDR_CMD_SERIAL = 8'h00;
    localparam logic [7:0] ADDR_CMD_I2C    = 8'h04;
    localparam logic [7:0] ADDR_PROT_CODE  = 8'h08;
    localparam logic [7:0] ADDR_STATUS     = 8'h0c;
    localparam logic [7:0] ADDR_PHRASE0    = 8'h10;
    localparam logic [7:0] ADDR_PHRASE_STEP = 8'h04;

    // Command opcodes
    localparam logic [3:0] OP_NIB_PHRASE_SEL = 4'h3;
    localparam logic [3:0] OP_NIB_PHRASE_CMD_A       = 4'h4;
    localparam logic [3:0] OP_NIB_START      = 4'h5;
    localparam logic [7:0] OP_FLASH_UNLOCK   = 8'h10;
    localparam logic [7:0] OP_WDT_CLEAR      = 8'h14;
    localparam logic [7:0] OP_POWER_DOWN     = 8'h20;

    // Protection code that locks out flash access while it is stored
    localparam logic [7:0] PROT_LOCKED       = 8'h69;
    localparam logic [7:0] PROT_CODE_RESET   = 8'h00;

    // Field positions in the first byte
    localparam int OP_MSB        = 7;
    localparam int OP_LSB        = 4;
    localparam int PHRASE_HI_MSB = 3;
    localparam int PHRASE_HI_LSB = 2;
    localparam int CHAN_MSB      = 1;
    localparam int CHAN_LSB      = 0;

    // Status register bit positions
    localparam int ST_FLASH_MODE = 0;
    localparam int ST_POWER_DOWN = 1;
    localparam int ST_OSC_STOP   = 2;
    localparam int ST_PENDING    = 3;
    localparam int ST_REFUSED    = 4;

    localparam int NUM_CHAN   = 4;
    localparam int PHRASE_W   = 10;
    localparam logic [PHRASE_W-1:0] PHRASE_RESET = 10'h000;

    // Power-down processing time and its cycle count at 40 MHz
    localparam int CLK_PERIOD_NS = 25;
    localparam int PD_TIME_NS    = 1000;
    localparam int PD_CYCLES     = (PD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PD_CNT_W      = 8;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_BYTE2 = 2'b01,
        ST_PDWAIT = 2'b10,
        ST_PDOWN = 2'b11
    } spc_state_type;

    // Analog pin conditions while powered down
    typedef struct packed {
        logic left_reg_grounded;
        logic right_reg_grounded;
        logic ground_ref_grounded;
        logic spk_neg_hiz;
        logic spk_pos_to_spk_gnd;
    } spc_pins_type;

endpackage

// ===== rtl/spc_cmd_decoder.sv
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ps

module spc_cmd_decoder (
    input  wire logic                                   clk,
    input  wire logic                                   rst,
    input  wire logic [7:0]                             addr,
    input  wire logic [7:0]                             wdata,
    input  wire logic                                   wr,
    input  wire logic                                   rd,
    output logic      [31:0]                            rdata,
    input  wire logic [spc_pkg::NUM_CHAN-1:0]           command_ready_n,
    input  wire logic [spc_pkg::NUM_CHAN-1:0]           channel_busy_n,
    output logic [spc_pkg::NUM_CHAN-1:0]                phrase_cmd_a_start,
    output logic [spc_pkg::NUM_CHAN*spc_pkg::PHRASE_W-1:0] phrase_cmd_a_phrase,
    output logic                                        watchdog_clear,
    output logic                                        flash_access_mode,
    output logic                                        power_down,
    output logic                                        osc_stop,
    output spc_pkg::spc_pins_type                       pin_state
);

    // Channel one-hot from the 2-bit field
    function automatic logic [spc_pkg::NUM_CHAN-1:0] chan_onehot(input logic [1:0] sel);
        chan_onehot = 4'h1 << sel;
    endfunction

    spc_pkg::spc_state_type         state_q, state_d;
    logic [7:0]                     first_q;
    logic                           first_i2c_q;
    logic [7:0]                     prot_q;
    logic                           flash_q;
    logic                           refused_q, refused_d;
    logic [spc_pkg::PD_CNT_W-1:0]   pd_cnt_q;
    logic                           osc_stop_q;
    logic [spc_pkg::NUM_CHAN-1:0]   start_q, start_d;
    logic                           wdt_q, wdt_d;
    logic                           flash_set;
    logic [spc_pkg::PHRASE_W-1:0]   phrase_q [spc_pkg::NUM_CHAN];
    logic [31:0]                    rdata_q;

    // Bus decode
    wire        wr_ser     = wr && (addr == spc_pkg::ADDR_CMD_SERIAL);
    wire        wr_i2c     = wr && (addr == spc_pkg::ADDR_CMD_I2C);
    wire        wr_prot    = wr && (addr == spc_pkg::ADDR_PROT_CODE);
    wire        cmd_valid  = wr_ser || wr_i2c;
    wire [3:0]  op_nib     = wdata[spc_pkg::OP_MSB:spc_pkg::OP_LSB];
    wire [3:0]  first_nib  = first_q[spc_pkg::OP_MSB:spc_pkg::OP_LSB];
    wire [1:0]  first_chan = first_q[spc_pkg::CHAN_MSB:spc_pkg::CHAN_LSB];
    wire [3:0]  chan_bits  = wdata[spc_pkg::NUM_CHAN-1:0];
    wire [3:0]  ready      = command_ready_n;

    // Two-byte commands wait for their second byte
    wire two_byte = (op_nib == spc_pkg::OP_NIB_PHRASE_SEL) || (op_nib == spc_pkg::OP_NIB_PHRASE_CMD_A)
                 || (wdata == spc_pkg::OP_FLASH_UNLOCK);

    // Ten-bit phrase: upper two bits from first byte, low byte second
    wire [spc_pkg::PHRASE_W-1:0] new_phrase =
        {first_q[spc_pkg::PHRASE_HI_MSB:spc_pkg::PHRASE_HI_LSB], wdata};
    wire [3:0]  target     = chan_onehot(first_chan);
    wire        target_rdy = |(target & ready);
    wire        sel_exec   = (state_q == spc_pkg::ST_BYTE2) && cmd_valid && target_rdy
                          && (first_nib == spc_pkg::OP_NIB_PHRASE_SEL);
    wire        phrase_cmd_a_exec  = (state_q == spc_pkg::ST_BYTE2) && cmd_valid && target_rdy
                          && (first_nib == spc_pkg::OP_NIB_PHRASE_CMD_A);
    wire        all_idle   = &channel_busy_n;

    // Unlock needs a code other than the lockout value, matching, opcode byte not from I2C
    wire unlock_ok = (prot_q != spc_pkg::PROT_LOCKED) && (wdata == prot_q) && !first_i2c_q;

    // Command sequencer
    always_comb begin
        state_d   = state_q;
        start_d   = '0;
        wdt_d     = 1'b0;
        flash_set = 1'b0;
        refused_d = refused_q;
        case (state_q)
            spc_pkg::ST_IDLE: begin
                if (cmd_valid) begin
                    refused_d = 1'b0;
                    if (two_byte) begin
                        state_d = spc_pkg::ST_BYTE2;
                    end else if (wdata == spc_pkg::OP_WDT_CLEAR) begin
                        wdt_d = 1'b1;
                    end else if (wdata == spc_pkg::OP_POWER_DOWN) begin
                        if (all_idle) begin
                            state_d = spc_pkg::ST_PDWAIT;
                        end else begin
                            refused_d = 1'b1;
                        end
                    end else if (op_nib == spc_pkg::OP_NIB_START) begin
                        start_d   = chan_bits & ready;
                        refused_d = ((chan_bits & ready) != chan_bits) || (chan_bits == '0);
                    end
                end
            end
            spc_pkg::ST_BYTE2: begin
                if (cmd_valid) begin
                    state_d = spc_pkg::ST_IDLE;
                    if (first_q == spc_pkg::OP_FLASH_UNLOCK) begin
                        flash_set = unlock_ok;
                        refused_d = !unlock_ok;
                    end else begin
                        refused_d = !target_rdy;
                        if (phrase_cmd_a_exec) begin
                            start_d = target;
                        end
                    end
                end
            end
            spc_pkg::ST_PDWAIT: begin
                if (pd_cnt_q == spc_pkg::PD_CNT_W'(spc_pkg::PD_CYCLES - 1)) begin
                    state_d = spc_pkg::ST_PDOWN;
                end
            end
            default: begin
                state_d = spc_pkg::ST_PDOWN; // Stays down until reset
            end
        endcase
    end

    // State, first byte and pulses
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q     <= spc_pkg::ST_IDLE;
            first_q     <= 8'h00;
            first_i2c_q <= 1'b0;
            refused_q   <= 1'b0;
            start_q     <= '0;
            wdt_q       <= 1'b0;
        end else begin
            state_q   <= state_d;
            refused_q <= refused_d;
            start_q   <= start_d;
            wdt_q     <= wdt_d;
            if (state_q == spc_pkg::ST_IDLE && cmd_valid) begin
                first_q     <= wdata;
                first_i2c_q <= wr_i2c;
            end
        end
    end

    // Flash mode is sticky; only reset leaves it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flash_q <= 1'b0;
        end else if (flash_set) begin
            flash_q <= 1'b1;
        end
    end

    // Stored area protection code; survives power-down like flash contents
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prot_q <= spc_pkg::PROT_CODE_RESET;
        end else if (wr_prot) begin
            prot_q <= wdata;
        end
    end

    // Power-down processing time, then oscillator stop
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pd_cnt_q   <= '0;
            osc_stop_q <= 1'b0;
        end else if (state_q == spc_pkg::ST_PDWAIT) begin
            pd_cnt_q <= pd_cnt_q + 1'b1;
        end else if (state_q == spc_pkg::ST_PDOWN) begin
            osc_stop_q <= 1'b1;
        end
    end

    // Per-channel phrase store, cleared on power-down entry
    genvar g;
    generate
        for (g = 0; g < spc_pkg::NUM_CHAN; g++) begin : g_chan
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    phrase_q[g] <= spc_pkg::PHRASE_RESET;
                end else if (state_d == spc_pkg::ST_PDWAIT) begin
                    phrase_q[g] <= spc_pkg::PHRASE_RESET;
                end else if ((sel_exec || phrase_cmd_a_exec) && target[g]) begin
                    phrase_q[g] <= new_phrase;
                end
            end
            assign phrase_cmd_a_phrase[g*spc_pkg::PHRASE_W +: spc_pkg::PHRASE_W] = phrase_q[g];
        end
    endgenerate

    // Read path: one cycle after the strobe, zero elsewhere
    wire [7:0] ph_off = addr - spc_pkg::ADDR_PHRASE0;
    wire [1:0] ph_idx = ph_off[3:2];
    wire       ph_hit = (addr >= spc_pkg::ADDR_PHRASE0)
                     && (addr < spc_pkg::ADDR_PHRASE0 + 8'(spc_pkg::NUM_CHAN) * spc_pkg::ADDR_PHRASE_STEP)
                     && (addr[1:0] == 2'b00);
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (addr == spc_pkg::ADDR_PROT_CODE) begin
            rd_mux[7:0] = prot_q;
        end else if (addr == spc_pkg::ADDR_STATUS) begin
            rd_mux[spc_pkg::ST_FLASH_MODE] = flash_q;
            rd_mux[spc_pkg::ST_POWER_DOWN] = power_down;
            rd_mux[spc_pkg::ST_OSC_STOP]   = osc_stop_q;
            rd_mux[spc_pkg::ST_PENDING]    = (state_q == spc_pkg::ST_BYTE2);
            rd_mux[spc_pkg::ST_REFUSED]    = refused_q;
        end else if (ph_hit) begin
            rd_mux[spc_pkg::PHRASE_W-1:0] = phrase_q[ph_idx];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rd ? rd_mux : 32'h0000_0000;
        end
    end

    // Outputs
    assign rdata             = rdata_q;
    assign phrase_cmd_a_start        = start_q;
    assign watchdog_clear    = wdt_q;
    assign flash_access_mode = flash_q;
    assign osc_stop          = osc_stop_q;
    assign power_down        = (state_q == spc_pkg::ST_PDWAIT) || (state_q == spc_pkg::ST_PDOWN);
    assign pin_state         = {5{power_down}};

endmodule

// ===== sim/spc_cmd_decoder_chk.sv
`timescale 1ns/1ps

module spc_cmd_decoder_chk (
    input wire logic                          clk,
    input wire logic                          rst,
    input wire logic [7:0]                    addr,
    input wire logic [7:0]                    wdata,
    input wire logic                          wr,
    input wire logic                          rd,
    input wire logic [31:0]                   rdata,
    input wire logic [spc_pkg::NUM_CHAN-1:0]  command_ready_n,
    input wire logic [spc_pkg::NUM_CHAN-1:0]  channel_busy_n,
    input wire logic [spc_pkg::NUM_CHAN-1:0]  phrase_cmd_a_start,
    input wire logic                          watchdog_clear,
    input wire logic                          flash_access_mode,
    input wire logic                          power_down,
    input wire logic                          osc_stop,
    input wire spc_pkg::spc_pins_type         pin_state
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Command write on either path, and second-byte tracking
    wire  cmd_w = wr && (addr == spc_pkg::ADDR_CMD_SERIAL || addr == spc_pkg::ADDR_CMD_I2C);
    wire  two_b = wdata[7:4] == spc_pkg::OP_NIB_PHRASE_SEL || wdata[7:4] == spc_pkg::OP_NIB_PHRASE_CMD_A
                  || wdata == spc_pkg::OP_FLASH_UNLOCK;
    logic pend_q;
    // Mirrors the pending flag so a data byte is never mistaken for an opcode
    always_ff @(posedge clk or posedge rst) begin
        if (rst) pend_q <= 1'b0;
        else if (cmd_w && !power_down) pend_q <= !pend_q && two_b;
    end
    a_wdt_any_ready: assert property (cmd_w && !pend_q && !power_down && wdata == spc_pkg::OP_WDT_CLEAR
        |=> watchdog_clear) else $error("watchdog clear missing");
    a_wdt_cause: assert property (watchdog_clear |-> $past(cmd_w && wdata == spc_pkg::OP_WDT_CLEAR))
        else $error("stray watchdog clear");
    a_flash_sticky: assert property (flash_access_mode |=> flash_access_mode) else $error("flash mode left");
    a_pd_needs_idle: assert property ($rose(power_down) |-> $past(&channel_busy_n && cmd_w
        && wdata == spc_pkg::OP_POWER_DOWN)) else $error("power-down without cause");
    a_pd_sticky: assert property (power_down |=> power_down) else $error("power-down left");
    a_pins_follow: assert property (pin_state == {5{power_down}}) else $error("pin state wrong");
    a_osc_late: assert property ($rose(power_down) |-> !osc_stop [*8] ##[30:40] osc_stop)
        else $error("oscillator stop timing");
    a_osc_only_pd: assert property (osc_stop |-> power_down) else $error("oscillator stopped early");
    a_start_ready: assert property ((phrase_cmd_a_start & ~$past(command_ready_n)) == 4'h0)
        else $error("start on unready channel");
    a_start_cause: assert property (|phrase_cmd_a_start |-> $past(cmd_w)) else $error("start without command");
    a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0) else $error("read data outside slot");
endmodule

bind spc_cmd_decoder spc_cmd_decoder_chk u_chk (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .command_ready_n(command_ready_n), .channel_busy_n(channel_busy_n),
    .phrase_cmd_a_start(phrase_cmd_a_start), .watchdog_clear(watchdog_clear), .flash_access_mode(flash_access_mode),
    .power_down(power_down), .osc_stop(osc_stop), .pin_state(pin_state));

// ===== sim/spc_chan_model.sv
`timescale 1ns/1ps

// Playback side: a started channel is busy and unready for seven cycles
module spc_chan_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [3:0]  phrase_cmd_a_start,
    input  wire logic [3:0]  ready_mask,
    output logic      [3:0]  command_ready_n,
    output logic      [3:0]  channel_busy_n
);
    logic [3:0][2:0] busy_q;
    // Short busy time keeps the run brief but still overlaps later commands
    always_ff @(posedge clk or posedge rst) begin
        for (int i = 0; i < 4; i++) begin
            if (rst) busy_q[i] <= 3'h0;
            else if (phrase_cmd_a_start[i]) busy_q[i] <= 3'h7;
            else if (busy_q[i] != 3'h0) busy_q[i] <= busy_q[i] - 3'h1;
        end
    end
    always_comb begin
        for (int i = 0; i < 4; i++) channel_busy_n[i] = busy_q[i] == 3'h0;
    end
    assign command_ready_n = ready_mask & channel_busy_n;
endmodule

// ===== sim/spc_cmd_decoder_tb.sv
`timescale 1ns/1ps

module spc_cmd_decoder_tb;
    logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
    logic [7:0]  addr = 8'h00, wdata = 8'h00;
    logic [3:0]  ready_mask = 4'hf, rdy_n, busy_n, phrase_cmd_a_start;
    logic [31:0] rdata, v;
    logic [39:0] phrase_cmd_a_phrase;
    logic        wdt, flash, pd, osc;
    spc_pkg::spc_pins_type pins;
    int          num_errors = 0, comparisons = 0, cycles = 0;

    spc_cmd_decoder dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .command_ready_n(rdy_n), .channel_busy_n(busy_n), .phrase_cmd_a_start(phrase_cmd_a_start), .phrase_cmd_a_phrase(phrase_cmd_a_phrase),
        .watchdog_clear(wdt), .flash_access_mode(flash), .power_down(pd), .osc_stop(osc), .pin_state(pins));
    spc_chan_model u_chan (.clk(clk), .rst(rst), .phrase_cmd_a_start(phrase_cmd_a_start), .ready_mask(ready_mask),
        .command_ready_n(rdy_n), .channel_busy_n(busy_n));

    initial begin
        forever #12.5 clk = ~clk;
    end
    // Hang guard, far above the roughly 160 cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            conclude();
        end
    end

    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic get(input logic [7:0] a, output logic [31:0] r);
        @(posedge clk);
        addr <= a; rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        r = rdata;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Each channel gets a phrase, ch0 at the top of the range, ch2 opcode byte via I2C path
    task automatic t_select();
        for (int c = 0; c < 4; c++) begin
            put(c == 2 ? spc_pkg::ADDR_CMD_I2C : spc_pkg::ADDR_CMD_SERIAL, {4'h3, 2'h3, 2'(c)});
            put(spc_pkg::ADDR_CMD_SERIAL, 8'hff ^ 8'(c));
        end
        for (int c = 0; c < 4; c++) begin
            chk(40'(phrase_cmd_a_phrase[10*c +: 10]), 40'(10'h3ff ^ 10'(c)));
            get(8'h10 + 8'(4 * c), v);
            chk(40'(v), 40'(10'h3ff ^ 10'(c)));
        end
    endtask
    task automatic t_phrase_cmd_a();
        put(spc_pkg::ADDR_CMD_SERIAL, 8'h45);
        put(spc_pkg::ADDR_CMD_SERIAL, 8'h12);
        chk(40'(phrase_cmd_a_start), 40'h2);
        chk(40'(phrase_cmd_a_phrase[19:10]), 40'h112);
        put(spc_pkg::ADDR_CMD_SERIAL, 8'h45);
        put(spc_pkg::ADDR_CMD_SERIAL, 8'h34);
        chk(40'(phrase_cmd_a_start), 40'h0);
        put(spc_pkg::ADDR_CMD_SERIAL, spc_pkg::OP_POWER_DOWN);
        chk(40'(pd), 40'h0);
        idle(8);
    endtask
    task automatic t_start();
        ready_mask <= 4'hb;
        put(spc_pkg::ADDR_CMD_SERIAL, 8'h5f);
        chk(40'(phrase_cmd_a_start), 40'hb);
        ready_mask <= 4'hf;
        idle(8);
        put(spc_pkg::ADDR_CMD_SERIAL, 8'h50);
        chk(40'(phrase_cmd_a_start), 40'h0);
        get(spc_pkg::ADDR_STATUS, v);
        chk(40'(v[spc_pkg::ST_REFUSED]), 40'h1);
        ready_mask <= 4'h0;
        put(spc_pkg::ADDR_CMD_SERIAL, spc_pkg::OP_WDT_CLEAR);
        chk(40'(wdt), 40'h1);
        ready_mask <= 4'hf;
    endtask
    task automatic unlock(input logic [7:0] a, input logic [7:0] code);
        put(a, spc_pkg::OP_FLASH_UNLOCK);
        put(a, code);
    endtask
    task automatic t_flash();
        put(spc_pkg::ADDR_PROT_CODE, spc_pkg::PROT_LOCKED);
        unlock(spc_pkg::ADDR_CMD_SERIAL, spc_pkg::PROT_LOCKED);
        chk(40'(flash), 40'h0);
        put(spc_pkg::ADDR_PROT_CODE, 8'h5a);
        unlock(spc_pkg::ADDR_CMD_I2C, 8'h5a);
        chk(40'(flash), 40'h0);
        unlock(spc_pkg::ADDR_CMD_SERIAL, 8'h5b);
        chk(40'(flash), 40'h0);
        unlock(spc_pkg::ADDR_CMD_SERIAL, 8'h5a);
        chk(40'(flash), 40'h1);
    endtask
    task automatic t_power();
        put(spc_pkg::ADDR_CMD_SERIAL, spc_pkg::OP_POWER_DOWN);
        chk(40'({pd, pins}), 40'h3f);
        chk(phrase_cmd_a_phrase, 40'h0);
        idle(50);
        chk(40'({osc, flash}), 40'h3);
        get(spc_pkg::ADDR_STATUS, v);
        chk(40'({v[spc_pkg::ST_OSC_STOP], v[spc_pkg::ST_POWER_DOWN], v[spc_pkg::ST_FLASH_MODE], v[spc_pkg::ST_PENDING]}), 40'he);
        rst <= 1'b1;
        idle(2);
        rst <= 1'b0;
        idle(2);
        chk(40'({osc, pd, flash}), 40'h0);
        get(spc_pkg::ADDR_PROT_CODE, v);
        chk(40'(v), 40'(spc_pkg::PROT_CODE_RESET));
        put(spc_pkg::ADDR_CMD_SERIAL, 8'h30);
        put(spc_pkg::ADDR_CMD_SERIAL, 8'h07);
        chk(40'(phrase_cmd_a_phrase[9:0]), 40'h007);
    endtask

    task automatic conclude();
        $display("comparisons %0d, num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        idle(16);
        rst <= 1'b0;
        idle(1);
        chk(40'({phrase_cmd_a_start, wdt, flash, pd, osc}), 40'h0);
        t_select();
        t_phrase_cmd_a();
        t_start();
        t_flash();
        t_power();
        conclude();
    end
endmodule
